// ===== src/power_mode_pkg.sv
// Package of constants and types for the gauge power-mode sequencer.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package power_mode_pkg;

   // ********************************************************************
   // Clock and times.
   // ********************************************************************
   localparam longint CLK_HZ = 100000000;
   localparam longint LINE_LOW_MS = 18000;          // Line-low time before sleep or ship.
   localparam longint WAKE_PERIOD_DS = 26160;       // Timed wake period, 43.6 min in 0.1 s.
   localparam longint LINE_LOW_CYCLES = (LINE_LOW_MS * CLK_HZ) / 1000;
   localparam longint WAKE_CYCLES = (WAKE_PERIOD_DS * CLK_HZ) / 10;
   localparam int CNT_W = 48;

   // ********************************************************************
   // Register map.
   // ********************************************************************
   localparam logic [6:0] ADDR_CTRL = 7'h00;        // Control command register.
   localparam logic [6:0] ADDR_MODE = 7'h01;        // Mode register.
   localparam logic [6:0] ADDR_CONFIG = 7'h02;      // Activity magnitude threshold.
   localparam logic [6:0] ADDR_STATUS = 7'h03;      // Power state and flags.
   localparam logic [6:0] ADDR_RETAIN = 7'h04;      // Retained-data valid flag.
   localparam logic [7:0] CMD_SHIP_ARM = 8'hA9;     // Control value that arms ship mode.
   localparam int MODE_SHIP_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [3:0] THRESH_RESET = 4'h0;

   // Power states.
   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_WAKE_CHECK,
      ST_SLEEP,
      ST_SHIP,
      ST_HIBERNATE
   } power_state_e;

endpackage

// ===== src/sync_two_ff.sv
// Two flip-flop synchroniser for a single level from outside the clock domain.
// Assumes the input may change at any time relative to clk_sys.
module sync_two_ff (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reset_level,
   input wire logic async_in,
   output logic sync_out
);

   logic stage_one;

   // Only the second stage reads the first.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stage_one <= reset_level;
         sync_out <= reset_level;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule // sync_two_ff

// ===== src/gauge_power_mode_control.sv
// Power-mode sequencer of a single-cell gas gauge: active, sleep, ship, hibernate.
// Assumes line, supply and activity inputs are asynchronous and pass synchronisers.
//
// Our own choices: strobed register access and the register addresses.
module gauge_power_mode_control #(
   // Timer limits in cycles; a bench may shorten them to reach sleep and ship.
   parameter longint LOW_LIMIT = power_mode_pkg::LINE_LOW_CYCLES,
   parameter longint WAKE_LIMIT = power_mode_pkg::WAKE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic single_wire_line,
   input wire logic two_wire_clock_line,
   input wire logic two_wire_data_line,
   input wire logic two_wire_mode,
   input wire logic activity_above_threshold,
   input wire logic avg_current_below_floor,
   input wire logic supply_above_por,
   input wire logic retention_supply_ok,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [3:0] activity_magnitude_threshold,
   output logic gauging_enable,
   output logic self_discharge_enable,
   output logic temp_hold,
   output logic temp_refresh,
   output logic functions_halted,
   output logic full_reset_req,
   output logic retain_gauge_data,
   output logic [2:0] power_state
);

   // ********************************************************************
   // Input synchronisers.
   // ********************************************************************
   logic swl_s, clk_line_s, data_line_s, act_s, avg_s, por_s, rbi_s;

   // Lines rest high and supply rests good after the synchroniser resets.
   sync_two_ff u_sync_swl (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b1),
      .async_in(single_wire_line), .sync_out(swl_s));
   sync_two_ff u_sync_clk (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b1),
      .async_in(two_wire_clock_line), .sync_out(clk_line_s));
   sync_two_ff u_sync_dta (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b1),
      .async_in(two_wire_data_line), .sync_out(data_line_s));
   sync_two_ff u_sync_act (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b0),
      .async_in(activity_above_threshold), .sync_out(act_s));
   sync_two_ff u_sync_avg (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b0),
      .async_in(avg_current_below_floor), .sync_out(avg_s));
   sync_two_ff u_sync_por (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b1),
      .async_in(supply_above_por), .sync_out(por_s));
   sync_two_ff u_sync_rbi (.clk_sys(clk_sys), .rst_n(rst_n), .reset_level(1'b0),
      .async_in(retention_supply_ok), .sync_out(rbi_s));

   // ********************************************************************
   // Line and activity decode.
   // ********************************************************************
   logic any_line_low, all_lines_high, activity_low;

   // The active interface picks which lines count.
   assign any_line_low = two_wire_mode ? (!clk_line_s || !data_line_s) : !swl_s;
   assign all_lines_high = !any_line_low;
   // A zero threshold also asks for the average current to be small.
   assign activity_low = !act_s &&
      ((activity_magnitude_threshold != 4'h0) || avg_s);

   // ********************************************************************
   // Registers and bus.
   // ********************************************************************
   logic [7:0] mode_reg;
   logic ship_armed;
   logic retained;
   power_mode_pkg::power_state_e state, next_state;
   // Local names for the power states, so the logic below reads plainly.
   localparam power_mode_pkg::power_state_e ST_ACTIVE = power_mode_pkg::ST_ACTIVE;
   localparam power_mode_pkg::power_state_e ST_WAKE_CHECK = power_mode_pkg::ST_WAKE_CHECK;
   localparam power_mode_pkg::power_state_e ST_SLEEP = power_mode_pkg::ST_SLEEP;
   localparam power_mode_pkg::power_state_e ST_SHIP = power_mode_pkg::ST_SHIP;
   localparam power_mode_pkg::power_state_e ST_HIBERNATE = power_mode_pkg::ST_HIBERNATE;
   logic wr_ctrl, wr_mode, wr_cfg, arm_cmd, rd_hit;
   logic [7:0] rd_mux;

   assign wr_ctrl = reg_wr && (reg_addr == power_mode_pkg::ADDR_CTRL);
   assign wr_mode = reg_wr && (reg_addr == power_mode_pkg::ADDR_MODE);
   assign wr_cfg = reg_wr && (reg_addr == power_mode_pkg::ADDR_CONFIG);
   assign arm_cmd = wr_ctrl && (reg_wdata == power_mode_pkg::CMD_SHIP_ARM)
      && mode_reg[power_mode_pkg::MODE_SHIP_BIT];

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      rd_mux = 8'h00;
      if (reg_addr == power_mode_pkg::ADDR_MODE) begin
         rd_mux = mode_reg;
      end else if (reg_addr == power_mode_pkg::ADDR_CONFIG) begin
         rd_mux = {4'h0, activity_magnitude_threshold};
      end else if (reg_addr == power_mode_pkg::ADDR_STATUS) begin
         rd_mux = {3'h0, ship_armed, any_line_low, 3'(state)};
      end else if (reg_addr == power_mode_pkg::ADDR_RETAIN) begin
         rd_mux = {7'h00, retained};
      end
   end
   assign rd_hit = reg_rd;

   // Register writes and read data, held one cycle after the strobe.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_reg <= power_mode_pkg::MODE_RESET;
         activity_magnitude_threshold <= power_mode_pkg::THRESH_RESET;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_mode) mode_reg <= reg_wdata;
         if (wr_cfg) activity_magnitude_threshold <= reg_wdata[3:0];
         reg_rdata <= rd_hit ? rd_mux : 8'h00;
      end
   end

   // ********************************************************************
   // Timers.
   // ********************************************************************
   logic [power_mode_pkg::CNT_W-1:0] low_cnt, wake_cnt;
   // Limits are cut to the counter width; both fit with room to spare.
   typedef logic [power_mode_pkg::CNT_W-1:0] cnt_t;
   logic low_done, wake_due;

   assign low_done = (low_cnt >= cnt_t'(LOW_LIMIT));
   assign wake_due = (wake_cnt >= cnt_t'(WAKE_LIMIT - 1));

   // Line-low timer counts while any line of the active interface is low, clears when all of those lines are high.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         low_cnt <= '0;
      end else if (all_lines_high) begin
         low_cnt <= '0;
      end else if (!low_done) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // Wake timer runs only in sleep.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state != ST_SLEEP) begin
         wake_cnt <= '0;
      end else begin
         wake_cnt <= wake_cnt + 1'b1;
      end
   end

   // ********************************************************************
   // Power state machine.
   // ********************************************************************
   always_comb begin
      next_state = state;
      case (state)
         ST_ACTIVE: begin
            // Ship wins over sleep once armed; transients only restart the timer.
            if (ship_armed && low_done) next_state = ST_SHIP;
            else if (!ship_armed && low_done && activity_low) next_state = ST_SLEEP;
         end
         ST_WAKE_CHECK: begin
            if (all_lines_high) next_state = ST_ACTIVE;
            else if (activity_low && low_done) next_state = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (all_lines_high) next_state = ST_ACTIVE;
            else if (wake_due) next_state = ST_WAKE_CHECK;
         end
         ST_SHIP: begin
            // Wakes once every line that counts is high; normal sleep rules then apply.
            if (all_lines_high) next_state = ST_ACTIVE;
         end
         default: next_state = ST_ACTIVE;
      endcase
      if (!por_s) next_state = ST_HIBERNATE;
      else if (state == ST_HIBERNATE) next_state = ST_ACTIVE;
   end

   logic leaving_ship;
   assign leaving_ship = (state == ST_SHIP) && (next_state != ST_SHIP);

   // State, arming and retention flag.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= ST_ACTIVE;
         ship_armed <= 1'b0;
         full_reset_req <= 1'b0;
         retained <= 1'b0;
      end else begin
         state <= next_state;
         full_reset_req <= leaving_ship;
         if (state == ST_SHIP) ship_armed <= 1'b0;
         else if (arm_cmd) ship_armed <= 1'b1;
         if (state == ST_HIBERNATE && next_state == ST_ACTIVE) retained <= rbi_s;
         else if (leaving_ship) retained <= 1'b0;
      end
   end

   // ********************************************************************
   // Outputs.
   // ********************************************************************
   assign power_state = 3'(state);
   assign gauging_enable = (state == ST_ACTIVE) || (state == ST_WAKE_CHECK);
   assign self_discharge_enable = (state != ST_SHIP) && (state != ST_HIBERNATE);
   assign temp_hold = (state == ST_SLEEP);
   assign temp_refresh = (state == ST_SLEEP) && wake_due;
   assign functions_halted = (state == ST_SHIP) || (state == ST_HIBERNATE);
   assign retain_gauge_data = retained;

   // ********************************************************************
   // Assertions.
   // ********************************************************************
   property p_sleep_entry;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_ACTIVE && !ship_armed && low_done && activity_low && por_s)
      |=> (state == ST_SLEEP);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_wake_lines;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SLEEP && all_lines_high && por_s) |=> (state == ST_ACTIVE);
   endproperty
   a_wake_lines: assert property (p_wake_lines) else $error("sleep not left");

   property p_zero_thresh;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_ACTIVE && activity_magnitude_threshold == 4'h0 && !avg_s)
      |=> (state != ST_SLEEP);
   endproperty
   a_zero_thresh: assert property (p_zero_thresh) else $error("slept above floor");

   property p_arm;
      @(posedge clk_sys) disable iff (!rst_n)
      (arm_cmd && state != ST_SHIP) |=> ship_armed;
   endproperty
   a_arm: assert property (p_arm) else $error("ship not armed");

   property p_ship_needs_arm;
      @(posedge clk_sys) disable iff (!rst_n)
      (state != ST_SHIP) ##1 (state == ST_SHIP) |-> $past(ship_armed) && $past(low_done);
   endproperty
   a_ship_needs_arm: assert property (p_ship_needs_arm) else $error("bad ship entry");

   property p_ship_exit_reset;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SHIP) ##1 (state != ST_SHIP) |-> full_reset_req;
   endproperty
   a_ship_exit_reset: assert property (p_ship_exit_reset) else $error("no reset on exit");

   property p_hibernate;
      @(posedge clk_sys) disable iff (!rst_n)
      !por_s |=> (state == ST_HIBERNATE);
   endproperty
   a_hibernate: assert property (p_hibernate) else $error("hibernate missed");

   property p_timer_restart;
      @(posedge clk_sys) disable iff (!rst_n)
      all_lines_high |=> (low_cnt == '0);
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("timer not cleared");

   property p_sleep_outputs;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SLEEP) |-> temp_hold && !gauging_enable && self_discharge_enable;
   endproperty
   a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong");

   property p_timed_wake;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SLEEP && wake_due && any_line_low && por_s) |=> (state == ST_WAKE_CHECK);
   endproperty
   a_timed_wake: assert property (p_timed_wake) else $error("timed wake missed");

   property p_resleep;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_WAKE_CHECK && any_line_low && activity_low && low_done && por_s)
      |=> (state == ST_SLEEP);
   endproperty
   a_resleep: assert property (p_resleep) else $error("no return to sleep");

   property p_ship_wake;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SHIP && all_lines_high && por_s) |=> (state == ST_ACTIVE);
   endproperty
   a_ship_wake: assert property (p_ship_wake) else $error("ship not left");

   property p_ship_halt;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_SHIP) |-> functions_halted && !gauging_enable && !self_discharge_enable;
   endproperty
   a_ship_halt: assert property (p_ship_halt) else $error("ship not halted");

   property p_retain;
      @(posedge clk_sys) disable iff (!rst_n)
      (state == ST_HIBERNATE && por_s) |=> (retain_gauge_data == $past(rbi_s));
   endproperty
   a_retain: assert property (p_retain) else $error("retention flag wrong");

endmodule // gauge_power_mode_control

// ===== tb/host_line_model.sv
// Behavioural model of the host processor that owns the gauge communication lines.
// Assumes the bench tells it which lines to hold low; it drives them from clk_sys edges.
module host_line_model (
   input wire logic clk_sys,
   input wire logic [2:0] hold_low,
   output logic single_wire_line,
   output logic two_wire_clock_line,
   output logic two_wire_data_line
);
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************************************************
   // Line drivers.
   // ********************************************************************
   // A line not asked low is driven firmly high, so it never runs the line-low timer.
   initial begin
      single_wire_line = 1'b1;
      two_wire_clock_line = 1'b1;
      two_wire_data_line = 1'b1;
   end

   // Levels change only just after a rising edge, like a real host output port.
   always @(posedge clk_sys) begin
      single_wire_line <= ~hold_low[0];
      two_wire_clock_line <= ~hold_low[1];
      two_wire_data_line <= ~hold_low[2];
   end
endmodule // host_line_model

// ===== tb/gauge_power_mode_control_tb.sv
// Self-checking bench for the gauge power-mode sequencer.
// Assumes the package constants and a host line model; timer limits are shortened.
module gauge_power_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************************************************
   // Signals and instances.
   // ********************************************************************
   localparam logic [2:0] S_ACT = power_mode_pkg::ST_ACTIVE;
   localparam logic [2:0] S_HIB = power_mode_pkg::ST_HIBERNATE;
   localparam logic [2:0] S_SLP = power_mode_pkg::ST_SLEEP;
   localparam logic [2:0] S_WCK = power_mode_pkg::ST_WAKE_CHECK;
   localparam logic [2:0] S_SHP = power_mode_pkg::ST_SHIP;
   localparam int LOW_T = 40;   // Shortened line-low limit in cycles.
   localparam int WAKE_T = 30;  // Shortened timed-wake period in cycles.
   logic clk_sys, rst_n, two_wire_mode, activity_above_threshold, avg_current_below_floor;
   logic supply_above_por, retention_supply_ok, reg_wr, reg_rd;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd;
   logic [2:0] hold_low, power_state;
   logic [3:0] activity_magnitude_threshold;
   logic gauging_enable, retain_gauge_data, full_reset_req;
   logic self_discharge_enable, temp_hold, temp_refresh, functions_halted;
   wire single_wire_line, two_wire_clock_line, two_wire_data_line;
   int bad_count, checks_done;

   host_line_model u_host (.clk_sys(clk_sys), .hold_low(hold_low),
      .single_wire_line(single_wire_line), .two_wire_clock_line(two_wire_clock_line),
      .two_wire_data_line(two_wire_data_line));

   gauge_power_mode_control #(.LOW_LIMIT(LOW_T), .WAKE_LIMIT(WAKE_T)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .single_wire_line(single_wire_line), .two_wire_clock_line(two_wire_clock_line),
      .two_wire_data_line(two_wire_data_line), .two_wire_mode(two_wire_mode),
      .activity_above_threshold(activity_above_threshold),
      .avg_current_below_floor(avg_current_below_floor), .supply_above_por(supply_above_por),
      .retention_supply_ok(retention_supply_ok), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .activity_magnitude_threshold(activity_magnitude_threshold),
      .gauging_enable(gauging_enable), .self_discharge_enable(self_discharge_enable),
      .temp_hold(temp_hold), .temp_refresh(temp_refresh),
      .functions_halted(functions_halted), .full_reset_req(full_reset_req),
      .retain_gauge_data(retain_gauge_data), .power_state(power_state));

   // ********************************************************************
   // Clock, shared tasks and closing.
   // ********************************************************************
   // Free-running 100 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks made %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One-cycle write strobe beside address and data.
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the following cycle, then must clear.
   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk_sys);
      #1 check("rdata after read cycle", reg_rdata, 8'h00);
   endtask

   // Bounded wait for a power state, reported as a mismatch if it never comes.
   task automatic wait_state(input logic [2:0] st);
      int n;
      #1;
      for (n = 0; n < 60 && power_state !== st; n++) begin
         @(posedge clk_sys);
         #1;
      end
      check("power_state", {5'h00, power_state}, {5'h00, st});
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   // Lets line levels pass the model register and the two-stage synchroniser.
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // ********************************************************************
   // Scenarios.
   // ********************************************************************
   task automatic test_reset_values();
      wait_state(S_ACT);
      check("gauging in active", {7'h00, gauging_enable}, 8'h01);
      check("full reset pulse", {7'h00, full_reset_req}, 8'h00);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("status", rd, 8'h00);
      reg_read(power_mode_pkg::ADDR_MODE, rd);
      check("mode", rd, power_mode_pkg::MODE_RESET);
      reg_read(7'h10, rd);
      check("unmapped read", rd, 8'h00);
   endtask

   task automatic test_threshold();
      reg_write(power_mode_pkg::ADDR_CONFIG, 8'h0A);
      reg_write(7'h10, 8'h05);
      reg_read(power_mode_pkg::ADDR_CONFIG, rd);
      check("threshold reg", rd, 8'h0A);
      check("threshold out", {4'h0, activity_magnitude_threshold}, 8'h0A);
   endtask

   task automatic test_line_low();
      hold_low <= 3'b001;
      idle(4);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("single line low", rd, 8'h08);
      two_wire_mode <= 1'b1;
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("two-wire lines high", rd, 8'h00);
      hold_low <= 3'b100;
      idle(4);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("data line low", rd, 8'h08);
      hold_low <= 3'b000;
      two_wire_mode <= 1'b0;
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("all lines high", rd, 8'h00);
   endtask

   task automatic test_hibernate();
      supply_above_por <= 1'b0;
      wait_state(S_HIB);
      check("gauging in hibernate", {7'h00, gauging_enable}, 8'h00);
      supply_above_por <= 1'b1;
      wait_state(S_ACT);
      check("retain kept", {7'h00, retain_gauge_data}, 8'h01);
      retention_supply_ok <= 1'b0;
      supply_above_por <= 1'b0;
      wait_state(S_HIB);
      supply_above_por <= 1'b1;
      wait_state(S_ACT);
      check("retain lost", {7'h00, retain_gauge_data}, 8'h00);
      retention_supply_ok <= 1'b1;
   endtask

   task automatic test_ship_arm();
      reg_write(power_mode_pkg::ADDR_CTRL, power_mode_pkg::CMD_SHIP_ARM);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("arm without enable", rd, 8'h00);
      reg_write(power_mode_pkg::ADDR_MODE, 8'h01);
      reg_write(power_mode_pkg::ADDR_CTRL, 8'hA8);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("wrong control value", rd, 8'h00);
      reg_write(power_mode_pkg::ADDR_CTRL, power_mode_pkg::CMD_SHIP_ARM);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("armed", rd, 8'h10);
      hold_low <= 3'b001;
      idle(4);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      hold_low <= 3'b000;
      check("armed, line low", rd, 8'h18);
      idle(4);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("armed after transient", rd, 8'h10);
      do_reset();
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("armed cleared by reset", rd, 8'h00);
   endtask

   // Zero threshold holds off sleep until the average current is small.
   task automatic test_sleep();
      hold_low <= 3'b001;
      idle(LOW_T + 8);
      wait_state(S_ACT);
      avg_current_below_floor <= 1'b1;
      wait_state(S_SLP);
      check("temp hold", {7'h00, temp_hold}, 8'h01);
      check("gauging in sleep", {7'h00, gauging_enable}, 8'h00);
      check("self-discharge in sleep", {7'h00, self_discharge_enable}, 8'h01);
      repeat (WAKE_T - 2) @(posedge clk_sys);
      #1 check("refresh early", {7'h00, temp_refresh}, 8'h00);
      @(posedge clk_sys);
      #1 check("refresh", {7'h00, temp_refresh}, 8'h01);
      @(posedge clk_sys);
      #1 check("timed wake", {5'h00, power_state}, {5'h00, S_WCK});
      @(posedge clk_sys);
      #1 check("resleep", {5'h00, power_state}, {5'h00, S_SLP});
      hold_low <= 3'b000;
      wait_state(S_ACT);
   endtask

   // Armed ship entry, halt, exit with a reset pulse, then ordinary sleep.
   task automatic test_ship_mode();
      reg_write(power_mode_pkg::ADDR_MODE, 8'h01);
      reg_write(power_mode_pkg::ADDR_CTRL, power_mode_pkg::CMD_SHIP_ARM);
      hold_low <= 3'b001;
      wait_state(S_SHP);
      check("halted in ship", {7'h00, functions_halted}, 8'h01);
      check("self-discharge in ship", {7'h00, self_discharge_enable}, 8'h00);
      reg_read(power_mode_pkg::ADDR_STATUS, rd);
      check("arming spent", rd, 8'h0B);
      hold_low <= 3'b000;
      wait_state(S_ACT);
      check("reset pulse", {7'h00, full_reset_req}, 8'h01);
      @(posedge clk_sys);
      #1 check("reset pulse ends", {7'h00, full_reset_req}, 8'h00);
      hold_low <= 3'b001;
      wait_state(S_SLP);
      hold_low <= 3'b000;
      wait_state(S_ACT);
   endtask

   // ********************************************************************
   // Main sequence and watchdog.
   // ********************************************************************
   // All inputs get a value at time zero; reset is held for two cycles.
   initial begin
      bad_count = 0;
      checks_done = 0;
      rst_n = 1'b0;
      two_wire_mode = 1'b0;
      activity_above_threshold = 1'b0;
      avg_current_below_floor = 1'b0;
      supply_above_por = 1'b1;
      retention_supply_ok = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      hold_low = 3'b000;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      test_reset_values();
      test_threshold();
      test_line_low();
      test_hibernate();
      test_ship_arm();
      test_sleep();
      test_ship_mode();
      wrap_up();
   end

   // The scenarios take well under a thousand cycles; allow ten times that.
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end
endmodule // gauge_power_mode_control_tb
